// >>> bwc_pkg.sv
/*
 * Constants of the bus and wake control register group.
 * Assumes a host reaching the registers over a 16-bit serial frame.
 */
// Contract
// - Transceiver field 00 off, 01 wake-capable, 10 receive-only, 11 normal.
// - Reserved bits of all four registers always read back as zero.
// - Fail-safe entry forces transceiver field 01 and wake control x000 0111.
// - Restart loads transceiver field from cause input, upper bits zero.
// - Peak threshold bit: clear selects low threshold, set selects high.
// - Peak bit writable in init and normal only; stop ignores silently.
// - Internal wake bits 7 and 6 enable timer two and timer one wake.
// - Internal wake bit 2 is upper watchdog stop code bit; 00 keeps active.
// - External bit 7 clear: only wake events interrupt; set: all status.
// - Measure select set masks wake inputs one and two enables.
// - Measurement runs in normal mode; host ignores input one/two levels.
// - External bits 2,1,0 enable wake inputs three, two and one.
// - Power-on or soft reset loads external wake control 0000 0111.
// - Restart keeps timer wake enables, clears lower six internal bits.
// - Watchdog stop code bit 0 lives outside; code 11 disables watchdog.
package bwc_pkg;

    // ****************************************************************
    // Register addresses
    // ****************************************************************
    localparam logic [6:0] ADDR_TRX_MODE = 7'h04;
    localparam logic [6:0] ADDR_PEAK_THR = 7'h05;
    localparam logic [6:0] ADDR_INT_WAKE = 7'h06;
    localparam logic [6:0] ADDR_EXT_WAKE = 7'h07;

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int POS_PEAK_THR = 5;
    localparam int POS_TIMER2_WK = 7;
    localparam int POS_TIMER1_WK = 6;
    localparam int POS_WD_STOP_HI = 2;
    localparam int POS_INT_GLOBAL = 7;
    localparam int POS_MEASURE = 5;
    localparam int POS_WAKE3 = 2;
    localparam int POS_WAKE2 = 1;
    localparam int POS_WAKE1 = 0;

    // ****************************************************************
    // Reset and forced values
    // ****************************************************************
    localparam logic [1:0] RST_TRX_MODE = 2'h0;
    localparam logic RST_PEAK_THR = 1'b0;
    localparam logic [1:0] RST_TIMER_WK = 2'h0;
    localparam logic RST_WD_STOP_HI = 1'b0;
    localparam logic RST_INT_GLOBAL = 1'b0;
    localparam logic RST_MEASURE = 1'b0;
    localparam logic [2:0] RST_WAKE_EN = 3'h7;
    localparam logic [1:0] FS_TRX_MODE = 2'h1;
    localparam logic FS_MEASURE = 1'b0;
    localparam logic [2:0] FS_WAKE_EN = 3'h7;

    // ****************************************************************
    // Serial frame layout
    // ****************************************************************
    localparam logic [4:0] FRAME_BITS = 5'h10;
    localparam logic [4:0] ADDR_BITS = 5'h07;
    localparam logic [4:0] CMD_BITS = 5'h08;

    // ****************************************************************
    // Types
    // ****************************************************************
    typedef enum logic [2:0] {
        BWC_MODE_INIT = 3'b000,
        BWC_MODE_NORMAL = 3'b001,
        BWC_MODE_STOP = 3'b010,
        BWC_MODE_SLEEP = 3'b011,
        BWC_MODE_RESTART = 3'b100,
        BWC_MODE_FAIL_SAFE = 3'b101
    } bwc_mode_t;

    typedef enum logic [1:0] {
        BWC_TRX_OFF = 2'b00,
        BWC_TRX_WAKE = 2'b01,
        BWC_TRX_RX_ONLY = 2'b10,
        BWC_TRX_NORMAL = 2'b11
    } bwc_trx_mode_t;

endpackage

// >>> bwc_spi_frame.sv
/*
 * Serial frame receiver of the register group.
 * Assumes serial pins already synchronous to ref_clk_i and slower than it.
 */
`timescale 1ns/1ps
module bwc_spi_frame (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic spi_clk_i,
    input wire logic spi_cs_n_i,
    input wire logic spi_mosi_i,
    input wire logic [7:0] rd_data_i,
    output logic [6:0] addr_o,
    output logic wr_o,
    output logic [7:0] wr_data_o,
    output logic miso_o,
    output logic miso_oe_o
);
    import bwc_pkg::*;

    logic sclk_q_r;
    logic [4:0] cnt_r;
    logic [15:0] rx_r;
    logic [7:0] tx_r;
    logic rise;
    logic fall;

    assign rise = spi_clk_i & ~sclk_q_r & ~spi_cs_n_i;
    assign fall = ~spi_clk_i & sclk_q_r & ~spi_cs_n_i;

    // ****************************************************************
    // Shift in, LSB first: address, write flag, data
    // ****************************************************************
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            sclk_q_r <= 1'b0;
            cnt_r <= 5'h00;
            rx_r <= 16'h0000;
        end else begin
            sclk_q_r <= spi_clk_i;
            if (spi_cs_n_i) begin
                cnt_r <= 5'h00;
            end else if (rise && cnt_r != FRAME_BITS) begin
                rx_r <= {spi_mosi_i, rx_r[15:1]};
                cnt_r <= cnt_r + 5'h01;
            end
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            addr_o <= 7'h00;
        end else if (rise && cnt_r == ADDR_BITS - 5'h01) begin
            addr_o <= {spi_mosi_i, rx_r[15:10]};
        end
    end

    // Commit only whole frames of sixteen bits or more; bits past sixteen are dropped
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            wr_o <= 1'b0;
            wr_data_o <= 8'h00;
        end else begin
            wr_o <= spi_cs_n_i && cnt_r == FRAME_BITS && rx_r[7];
            wr_data_o <= rx_r[15:8];
        end
    end

    // ****************************************************************
    // Shift out old register content during data phase
    // ****************************************************************
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            tx_r <= 8'h00;
            miso_o <= 1'b0;
            miso_oe_o <= 1'b0;
        end else begin
            miso_oe_o <= ~spi_cs_n_i;
            if (spi_cs_n_i) begin
                tx_r <= 8'h00;
                miso_o <= 1'b0;
            end else begin
                if (rise && cnt_r == CMD_BITS - 5'h01) begin
                    tx_r <= rd_data_i;
                end else if (rise && cnt_r >= CMD_BITS) begin
                    tx_r <= {1'b0, tx_r[7:1]};
                end
                if (fall) begin
                    miso_o <= tx_r[0];
                end
            end
        end
    end

endmodule

// >>> bwc_ctrl_regs.sv
/*
 * Bus and wake control registers with their reset, restart and
 * fail-safe behaviour and the control outputs they drive.
 * Assumes mode and event inputs from the device state logic.
 */
`timescale 1ns/1ps
module bwc_ctrl_regs (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic soft_reset_i,
    input wire logic restart_entry_i,
    input wire logic [1:0] restart_trx_mode_i,
    input wire logic fail_safe_entry_i,
    input wire bwc_pkg::bwc_mode_t dev_mode_i,
    input wire logic wd_stop_disable_lo_i,
    input wire logic wake_event_i,
    input wire logic status_event_i,
    input wire logic spi_clk_i,
    input wire logic spi_cs_n_i,
    input wire logic spi_mosi_i,
    output logic spi_miso_o,
    output logic spi_miso_oe_o,
    output logic [1:0] trx_mode_o,
    output logic main_rail_peak_threshold_sel_o,
    output logic second_timer_wake_enable_o,
    output logic first_timer_wake_enable_o,
    output logic [1:0] watchdog_stop_code_o,
    output logic [2:0] wake_input_enable_o,
    output logic measure_active_o,
    output logic int_request_o
);
    import bwc_pkg::*;

    logic [6:0] addr;
    logic wr;
    logic [7:0] wdata;
    logic [7:0] rd_data;
    logic init_all;

    logic [1:0] trx_mode_r;
    logic peak_thr_r;
    logic [1:0] timer_wk_r;
    logic wd_stop_hi_r;
    logic int_global_r;
    logic measure_r;
    logic [2:0] wake_en_r;

    function automatic logic hit(input logic [6:0] a, input logic [6:0] t);
        hit = a == t;
    endfunction

    assign init_all = soft_reset_i;

    // ****************************************************************
    // Serial access
    // ****************************************************************
    bwc_spi_frame u_frame (
        .ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n_i),
        .spi_clk_i(spi_clk_i),
        .spi_cs_n_i(spi_cs_n_i),
        .spi_mosi_i(spi_mosi_i),
        .rd_data_i(rd_data),
        .addr_o(addr),
        .wr_o(wr),
        .wr_data_o(wdata),
        .miso_o(spi_miso_o),
        .miso_oe_o(spi_miso_oe_o)
    );

    // ****************************************************************
    // Read back, reserved positions tied low
    // ****************************************************************
    always_comb begin
        rd_data = 8'h00;
        if (hit(addr, ADDR_TRX_MODE)) begin
            rd_data[1:0] = trx_mode_r;
        end else if (hit(addr, ADDR_PEAK_THR)) begin
            rd_data[POS_PEAK_THR] = peak_thr_r;
        end else if (hit(addr, ADDR_INT_WAKE)) begin
            rd_data[POS_TIMER2_WK] = timer_wk_r[1];
            rd_data[POS_TIMER1_WK] = timer_wk_r[0];
            rd_data[POS_WD_STOP_HI] = wd_stop_hi_r;
        end else if (hit(addr, ADDR_EXT_WAKE)) begin
            rd_data[POS_INT_GLOBAL] = int_global_r;
            rd_data[POS_MEASURE] = measure_r;
            rd_data[POS_WAKE3] = wake_en_r[2];
            rd_data[POS_WAKE2] = wake_en_r[1];
            rd_data[POS_WAKE1] = wake_en_r[0];
        end
    end

    // ****************************************************************
    // Transceiver mode
    // ****************************************************************
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i || init_all) begin
            trx_mode_r <= RST_TRX_MODE;
        end else if (fail_safe_entry_i) begin
            trx_mode_r <= FS_TRX_MODE;
        end else if (restart_entry_i) begin
            trx_mode_r <= restart_trx_mode_i;
        end else if (wr && hit(addr, ADDR_TRX_MODE)) begin
            trx_mode_r <= wdata[1:0];
        end
    end

    // ****************************************************************
    // Peak threshold, locked outside init and normal
    // ****************************************************************
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i || init_all) begin
            peak_thr_r <= RST_PEAK_THR;
        end else if (wr && hit(addr, ADDR_PEAK_THR) &&
                     (dev_mode_i == BWC_MODE_INIT ||
                      dev_mode_i == BWC_MODE_NORMAL)) begin
            peak_thr_r <= wdata[POS_PEAK_THR];
        end
    end

    // ****************************************************************
    // Internal wake control
    // ****************************************************************
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i || init_all) begin
            timer_wk_r <= RST_TIMER_WK;
            wd_stop_hi_r <= RST_WD_STOP_HI;
        end else if (restart_entry_i) begin
            wd_stop_hi_r <= RST_WD_STOP_HI;
        end else if (wr && hit(addr, ADDR_INT_WAKE)) begin
            timer_wk_r <= {wdata[POS_TIMER2_WK],
                           wdata[POS_TIMER1_WK]};
            wd_stop_hi_r <= wdata[POS_WD_STOP_HI];
        end
    end

    // ****************************************************************
    // External wake control
    // ****************************************************************
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i || init_all) begin
            int_global_r <= RST_INT_GLOBAL;
            measure_r <= RST_MEASURE;
            wake_en_r <= RST_WAKE_EN;
        end else if (fail_safe_entry_i) begin
            measure_r <= FS_MEASURE;
            wake_en_r <= FS_WAKE_EN;
        end else if (wr && hit(addr, ADDR_EXT_WAKE)) begin
            int_global_r <= wdata[POS_INT_GLOBAL];
            measure_r <= wdata[POS_MEASURE];
            wake_en_r <= {wdata[POS_WAKE3], wdata[POS_WAKE2],
                          wdata[POS_WAKE1]};
        end
    end

    // ****************************************************************
    // Registered control outputs
    // ****************************************************************
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            trx_mode_o <= RST_TRX_MODE;
            main_rail_peak_threshold_sel_o <= RST_PEAK_THR;
            second_timer_wake_enable_o <= 1'b0;
            first_timer_wake_enable_o <= 1'b0;
            watchdog_stop_code_o <= 2'h0;
            wake_input_enable_o <= 3'h0;
            measure_active_o <= 1'b0;
            int_request_o <= 1'b0;
        end else begin
            trx_mode_o <= trx_mode_r;
            main_rail_peak_threshold_sel_o <= peak_thr_r;
            second_timer_wake_enable_o <= timer_wk_r[1];
            first_timer_wake_enable_o <= timer_wk_r[0];
            watchdog_stop_code_o <= {wd_stop_hi_r,
                                     wd_stop_disable_lo_i};
            wake_input_enable_o <= {wake_en_r[2],
                                    wake_en_r[1] & ~measure_r,
                                    wake_en_r[0] & ~measure_r};
            measure_active_o <= measure_r &&
                                dev_mode_i == BWC_MODE_NORMAL;
            int_request_o <= wake_event_i ||
                             (int_global_r && status_event_i);
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!rst_n_i);

    property p_trx_fail_safe;
        fail_safe_entry_i && !init_all |=> trx_mode_r == FS_TRX_MODE
            ##1 trx_mode_o == FS_TRX_MODE;
    endproperty
    a_trx_fail_safe: assert property (p_trx_fail_safe)
        else $error("fail-safe did not force wake-capable transceiver");

    property p_ext_fail_safe;
        fail_safe_entry_i && !init_all |=> wake_en_r == FS_WAKE_EN
            && !measure_r && $stable(int_global_r);
    endproperty
    a_ext_fail_safe: assert property (p_ext_fail_safe)
        else $error("fail-safe did not force external wake value");

    property p_trx_restart;
        restart_entry_i && !fail_safe_entry_i && !init_all |=>
            trx_mode_r == $past(restart_trx_mode_i);
    endproperty
    a_trx_restart: assert property (p_trx_restart)
        else $error("restart did not load transceiver cause value");

    property p_peak_locked;
        dev_mode_i == BWC_MODE_STOP && !init_all |=> $stable(peak_thr_r);
    endproperty
    a_peak_locked: assert property (p_peak_locked)
        else $error("peak threshold changed in stop mode");

    property p_restart_int_wake;
        restart_entry_i && !init_all |=> !wd_stop_hi_r
            && $stable(timer_wk_r);
    endproperty
    a_restart_int_wake: assert property (p_restart_int_wake)
        else $error("restart mishandled internal wake control");

    property p_reserved_zero;
        hit(addr, ADDR_TRX_MODE) |-> rd_data[7:2] == 6'h00;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero)
        else $error("reserved transceiver bits read non-zero");

    property p_measure_mask;
        measure_r ##1 measure_r |-> wake_input_enable_o[1:0] == 2'h0;
    endproperty
    a_measure_mask: assert property (p_measure_mask)
        else $error("wake inputs one or two enabled while measuring");

    property p_int_local;
        !int_global_r && !wake_event_i |=> !int_request_o;
    endproperty
    a_int_local: assert property (p_int_local)
        else $error("interrupt raised by status with global clear");

    property p_soft_ext;
        init_all |=> wake_en_r == RST_WAKE_EN && !measure_r
            ##1 wake_input_enable_o == RST_WAKE_EN;
    endproperty
    a_soft_ext: assert property (p_soft_ext)
        else $error("soft reset did not enable all wake inputs");

    property p_peak_write;
        wr && hit(addr, ADDR_PEAK_THR) && dev_mode_i == BWC_MODE_NORMAL
            && !init_all |=> peak_thr_r == $past(wdata[POS_PEAK_THR]);
    endproperty
    a_peak_write: assert property (p_peak_write)
        else $error("peak threshold write lost in normal mode");

    // Outputs lag registers by one cycle; skip the edge after reset
    property p_wake_out;
        $past(rst_n_i) && !$past(measure_r) |->
            wake_input_enable_o == $past(wake_en_r);
    endproperty
    a_wake_out: assert property (p_wake_out)
        else $error("wake input enables do not follow their bits");

    property p_wd_code;
        $past(rst_n_i) |-> watchdog_stop_code_o ==
            {$past(wd_stop_hi_r), $past(wd_stop_disable_lo_i)};
    endproperty
    a_wd_code: assert property (p_wd_code)
        else $error("watchdog stop code does not join its two bits");

    property p_measure_active;
        $past(rst_n_i) |-> measure_active_o ==
            ($past(measure_r) && $past(dev_mode_i) == BWC_MODE_NORMAL);
    endproperty
    a_measure_active: assert property (p_measure_active)
        else $error("measurement active outside normal mode");

endmodule

// >>> bwc_host_model.sv
/*
 * Host side model: a serial master that runs register frames.
 * Assumes the frame layout of bwc_ctrl_regs and a 4 ns reference clock.
 */
`timescale 1ns/1ps
module bwc_host_model (
    input wire logic ref_clk_i,
    input wire logic miso_i,
    output logic spi_clk_o,
    output logic spi_cs_n_o,
    output logic spi_mosi_o
);
    initial begin
        spi_clk_o = 1'b0;
        spi_cs_n_o = 1'b1;
        spi_mosi_o = 1'b0;
    end

    task automatic wait_clk(input int n);
        repeat (n) @(posedge ref_clk_i);
    endtask

    // **************************************************************
    // Frame: address, write flag, data, LSB first; four clocks per
    // serial half period. Level status bits are never consulted.
    // **************************************************************
    task automatic xfer(input logic [6:0] addr, input logic wr,
                        input logic [7:0] data, input int nbits,
                        output logic [7:0] rd);
        logic [15:0] word;
        logic [15:0] seen;
        word = {data, wr, addr};
        seen = 16'h0000;
        @(posedge ref_clk_i);
        spi_cs_n_o <= 1'b0;
        wait_clk(4);
        for (int i = 0; i < nbits; i++) begin
            spi_clk_o <= 1'b0;
            spi_mosi_o <= word[i];
            wait_clk(4);
            seen[i] = miso_i;
            spi_clk_o <= 1'b1;
            wait_clk(4);
        end
        spi_clk_o <= 1'b0;
        wait_clk(4);
        spi_cs_n_o <= 1'b1;
        // Released data line shows the inverse of its last bit
        spi_mosi_o <= ~spi_mosi_o;
        wait_clk(6);
        #1;
        rd = seen[15:8];
    endtask
endmodule

// >>> bwc_ctrl_regs_tb.sv
/*
 * Self-checking bench of bwc_ctrl_regs.
 * Assumes bwc_host_model as the serial master and a 250 MHz clock.
 */
`timescale 1ns/1ps
module bwc_ctrl_regs_tb;
    import bwc_pkg::*;

    typedef struct packed {
        logic [6:0] a;
        logic [7:0] d;
        logic [7:0] e;
    } bwc_row_t;

    localparam bwc_row_t ROWS [12] = '{
        '{7'h04, 8'hff, 8'h03}, '{7'h04, 8'h02, 8'h02},
        '{7'h04, 8'h00, 8'h00},
        '{7'h04, 8'h01, 8'h01}, // Bus wake capable
        '{7'h05, 8'hff, 8'h20}, '{7'h05, 8'hdf, 8'h00},
        '{7'h06, 8'hff, 8'hc4}, '{7'h06, 8'h3b, 8'h00},
        '{7'h07, 8'hff, 8'ha7}, '{7'h07, 8'h5c, 8'h04},
        '{7'h07, 8'h23, 8'h23}, '{7'h08, 8'hff, 8'h00}};

    logic ref_clk_i, rst_n_i, soft_reset_i, restart_entry_i;
    logic fail_safe_entry_i, wd_lo, wake_event_i, status_event_i;
    logic [1:0] restart_trx_mode_i;
    bwc_mode_t dev_mode_i;
    logic sclk, cs_n, mosi, miso, miso_oe, peak, t2_en, t1_en, meas, irq;
    logic [1:0] trx_mode, wd_code;
    logic [2:0] wake_en;
    logic [15:0] outs;
    logic [7:0] sh [4:7];
    logic [7:0] q;
    int n_fail, checks_done;

    assign outs = {5'h00, trx_mode, peak, t2_en, t1_en, wd_code, wake_en,
        meas};

    bwc_ctrl_regs DUT (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
        .soft_reset_i(soft_reset_i), .restart_entry_i(restart_entry_i),
        .restart_trx_mode_i(restart_trx_mode_i),
        .fail_safe_entry_i(fail_safe_entry_i), .dev_mode_i(dev_mode_i),
        .wd_stop_disable_lo_i(wd_lo), .wake_event_i(wake_event_i),
        .status_event_i(status_event_i), .spi_clk_i(sclk),
        .spi_cs_n_i(cs_n), .spi_mosi_i(mosi), .spi_miso_o(miso),
        .spi_miso_oe_o(miso_oe), .trx_mode_o(trx_mode),
        .main_rail_peak_threshold_sel_o(peak),
        .second_timer_wake_enable_o(t2_en),
        .first_timer_wake_enable_o(t1_en),
        .watchdog_stop_code_o(wd_code), .wake_input_enable_o(wake_en),
        .measure_active_o(meas), .int_request_o(irq));

    bwc_host_model host (.ref_clk_i(ref_clk_i), .miso_i(miso),
        .spi_clk_o(sclk), .spi_cs_n_o(cs_n), .spi_mosi_o(mosi));

    initial begin
        ref_clk_i = 1'b0;
        forever #2 ref_clk_i = ~ref_clk_i;
    end

    // **************************************************************
    // Shared tasks
    // **************************************************************
    task automatic check(input string what, input logic [15:0] seen,
                         input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask

    function automatic logic [15:0] img();
        img = {5'h00, sh[4][1:0], sh[5][5], sh[6][7], sh[6][6], sh[6][2],
               wd_lo, sh[7][2], sh[7][1] & ~sh[7][5], sh[7][0] & ~sh[7][5],
               sh[7][5] & (dev_mode_i == BWC_MODE_NORMAL)};
    endfunction

    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        logic [7:0] unused;
        host.xfer(a, 1'b1, d, 16, unused);
    endtask

    task automatic chk_all();
        logic [7:0] v;
        for (int a = 4; a < 8; a++) begin
            host.xfer(7'(a), 1'b0, 8'h00, 16, v);
            check("register", {8'h00, v}, {8'h00, sh[a]});
        end
        check("outputs", outs,
              img());
    endtask

    task automatic ev(input logic w, input logic s, input logic exp);
        @(posedge ref_clk_i);
        wake_event_i <= w;
        status_event_i <= s;
        @(posedge ref_clk_i);
        wake_event_i <= 1'b0;
        status_event_i <= 1'b0;
        #1;
        check("interrupt", {15'h0000, irq}, {15'h0000, exp});
        @(posedge ref_clk_i);
        #1;
        check("interrupt idle", {15'h0000, irq}, 16'h0000);
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        repeat (100000) @(posedge ref_clk_i);
        n_fail++;
        wrap_up();
    end

    // **************************************************************
    // Main sequence
    // **************************************************************
    initial begin
        {rst_n_i, soft_reset_i, restart_entry_i, fail_safe_entry_i} = 4'h0;
        {wd_lo, wake_event_i, status_event_i} = 3'h0;
        restart_trx_mode_i = 2'h0;
        dev_mode_i = BWC_MODE_INIT;
        n_fail = 0;
        checks_done = 0;
        sh = '{8'h00, 8'h00, 8'h00, 8'h07};
        repeat (5) @(posedge ref_clk_i);
        rst_n_i <= 1'b1;
        chk_all();
        @(posedge ref_clk_i);
        dev_mode_i <= BWC_MODE_NORMAL;
        wd_lo <= 1'b1;
        for (int i = 0; i < 12; i++) begin
            wr(ROWS[i].a, ROWS[i].d);
            if (ROWS[i].a inside {[7'h04:7'h07]}) begin
                sh[ROWS[i].a] = ROWS[i].e;
                chk_all();
            end else begin
                fork
                    host.xfer(ROWS[i].a, 1'b0, 8'h00, 16, q);
                    begin
                        repeat (20) @(posedge ref_clk_i);
                        #1;
                        check("drive enable", {15'h0000, miso_oe},
                              16'h0001);
                    end
                join
                check("drive enable idle", {15'h0000, miso_oe},
                      16'h0000);
                check("unmapped", {8'h00, q}, {8'h00, ROWS[i].e});
            end
        end
        // Peak bit frozen in stop mode
        wr(7'h05, 8'h20);
        sh[5] = 8'h20;
        @(posedge ref_clk_i);
        dev_mode_i <= BWC_MODE_STOP;
        wr(7'h05, 8'h00);
        chk_all();
        @(posedge ref_clk_i);
        dev_mode_i <= BWC_MODE_NORMAL;
        // Interrupt source selection
        wr(7'h07, 8'h00);
        sh[7] = 8'h00;
        ev(1'b0, 1'b1, 1'b0);
        ev(1'b1, 1'b0, 1'b1);
        wr(7'h07, 8'h80);
        ev(1'b0, 1'b1, 1'b1);
        // Fail-safe entry forces wake sources back on
        wr(7'h04, 8'h03);
        wr(7'h07, 8'ha2);
        @(posedge ref_clk_i);
        fail_safe_entry_i <= 1'b1;
        @(posedge ref_clk_i);
        fail_safe_entry_i <= 1'b0;
        sh[4] = 8'h01;
        sh[7] = 8'h87;
        chk_all();
        // Restart loads cause value, keeps timer enables
        wr(7'h06, 8'hc4);
        wr(7'h04, 8'h02);
        @(posedge ref_clk_i);
        restart_trx_mode_i <= 2'h3;
        restart_entry_i <= 1'b1;
        @(posedge ref_clk_i);
        restart_entry_i <= 1'b0;
        sh[4] = 8'h03;
        sh[6] = 8'hc0;
        chk_all();
        // Soft reset, then a second power-on reset mid-run
        wr(7'h07, 8'h20);
        @(posedge ref_clk_i);
        soft_reset_i <= 1'b1;
        @(posedge ref_clk_i);
        soft_reset_i <= 1'b0;
        sh = '{8'h00, 8'h00, 8'h00, 8'h07};
        chk_all();
        // Short write frame must leave every register alone
        host.xfer(7'h04, 1'b1, 8'h03, 15, q);
        chk_all();
        wr(7'h06, 8'hc4);
        @(posedge ref_clk_i);
        rst_n_i <= 1'b0;
        repeat (2) @(posedge ref_clk_i);
        rst_n_i <= 1'b1;
        chk_all();
        wrap_up();
    end
endmodule
